// file: logic/pmbus_tail_device.sv
// command-map tail device: decodes link transactions into its registers
//
// Design decision made here: the synchronised req/ack link port.
`timescale 1ns/100ps
module pmbus_tail_device
    import pmbus_tail_pkg::*;
#(
    parameter int DEPTH = pmbus_tail_pkg::LOG_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    pmbus_link_if.device link,
    input wire logic [15:0] iout_in,
    input wire logic [7:0] duty_in,
    input wire logic [15:0] die_temp_in,
    input wire logic fault_event_in,
    input wire logic [7:0] fault_byte_in,
    input wire logic store_all_in,
    input wire logic restore_all_in,
    output logic [7:0] pwm_mode_out,
    output logic ilim_high_range_out,
    output logic [1:0] comp_select_out,
    output logic [7:0] rail_group_address_out,
    output logic channel_off_out,
    output logic nvm_mismatch_out
);
    import pmbus_tail_pkg::*;
    // -----------------------------------------------------------------
    // link synchronisers and edge detect
    // -----------------------------------------------------------------
    logic [1:0] clk_sync_r, req_sync_r;
    logic clk_prev_r, req_seen_r;
    logic soft_rst_r;
    logic rst_any;
    assign rst_any = !rst_n_in || soft_rst_r;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            clk_sync_r <= 2'b00;
            req_sync_r <= 2'b00;
            clk_prev_r <= 1'b0;
        end else begin
            clk_sync_r <= {clk_sync_r[0], link.link_clk};
            req_sync_r <= {req_sync_r[0], link.req};
            clk_prev_r <= clk_sync_r[1];
        end
    end
    logic rise;
    assign rise = clk_sync_r[1] && !clk_prev_r;
    logic take;
    assign take = rise && req_sync_r[1] && !req_seen_r;
    // -----------------------------------------------------------------
    // register file and working copies
    // -----------------------------------------------------------------
    logic [7:0] cfg_r, mode_r, rail_r;
    logic [15:0] tc_r, rvin_r, slope_r, offs_r;
    logic [7:0] nv_cfg_r, nv_mode_r, nv_rail_r;
    logic [15:0] nv_tc_r, nv_rvin_r, nv_slope_r, nv_offs_r;
    logic [7:0] ram_log [DEPTH];
    logic [7:0] nv_log [DEPTH];
    logic [$clog2(DEPTH)-1:0] log_wp_r, rd_ptr_r;
    logic log_lock_r, comm_fault_r, ack_r, off_r, mismatch_r;
    logic [15:0] rdata_r, peak_r, iin_r;
    logic [2:0] listed;
    logic wr_kind;
    assign listed = listed_kind(link.cmd);
    assign wr_kind = link.kind == TX_WRITE_BYTE || link.kind == TX_WRITE_WORD;
    // input current: iout mantissa scaled by duty/256, exponent kept
    logic signed [19:0] iin_prod;
    assign iin_prod = signed'(iout_in[10:0]) * signed'({1'b0, duty_in});
    always_ff @(posedge clk_in) begin
        if (rst_any) iin_r <= 16'h0000;
        else iin_r <= {iout_in[15:11], iin_prod[18:8]};
    end
    // peak tracking
    always_ff @(posedge clk_in) begin
        if (rst_any) peak_r <= RST_PEAK_TEMP;
        else if (take && link.cmd == CMD_PEAK_CLEAR && link.kind == TX_SEND_BYTE)
            peak_r <= RST_PEAK_TEMP;
        else if (peak_r == RST_PEAK_TEMP || lin_gt(die_temp_in, peak_r))
            peak_r <= die_temp_in;
    end
    // compare two linear words by value
    function automatic logic lin_gt(input logic [15:0] a, input logic [15:0] b);
        logic signed [47:0] va, vb;
        va = 48'(signed'(a[10:0])) <<< (5'(signed'(a[15:11])) + 5'sd16);
        vb = 48'(signed'(b[10:0])) <<< (5'(signed'(b[15:11])) + 5'sd16);
        return va > vb;
    endfunction
    // writes, store, restore
    always_ff @(posedge clk_in) begin
        if (rst_any) begin
            cfg_r <= RST_PWM_PHASE_CONFIGURATION;
            mode_r <= RST_PWM_MODE_BYTE;
            rail_r <= RST_RAIL_GROUP_ADDRESS;
            tc_r <= RST_SENSE_TEMP_COEFFICIENT;
            rvin_r <= RST_INPUT_FILTER_RESISTANCE;
            slope_r <= RST_EXT_TEMP_SLOPE;
            offs_r <= RST_EXT_TEMP_OFFSET;
        end else if (restore_all_in) begin
            cfg_r <= nv_cfg_r;
            mode_r <= nv_mode_r;
            rail_r <= nv_rail_r;
            tc_r <= nv_tc_r;
            rvin_r <= nv_rvin_r;
            slope_r <= nv_slope_r;
            offs_r <= nv_offs_r;
        end else if (take && wr_kind && kind_ok(listed, link.kind)) begin
            if (link.cmd == CMD_PWM_PHASE_CONFIGURATION) cfg_r <= link.wdata[7:0];
            else if (link.cmd == CMD_PWM_MODE_BYTE) mode_r <= link.wdata[7:0];
            else if (link.cmd == CMD_RAIL_GROUP_ADDRESS) rail_r <= link.wdata[7:0];
            else if (link.cmd == CMD_SENSE_TEMP_COEFFICIENT) tc_r <= link.wdata;
            else if (link.cmd == CMD_INPUT_FILTER_RESISTANCE) rvin_r <= link.wdata;
            else if (link.cmd == CMD_EXT_TEMP_SLOPE) slope_r <= link.wdata;
            else if (link.cmd == CMD_EXT_TEMP_OFFSET) offs_r <= link.wdata;
        end
    end
    // nvm image survives soft restart
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            nv_cfg_r <= RST_PWM_PHASE_CONFIGURATION;
            nv_mode_r <= RST_PWM_MODE_BYTE;
            nv_rail_r <= RST_RAIL_GROUP_ADDRESS;
            nv_tc_r <= RST_SENSE_TEMP_COEFFICIENT;
            nv_rvin_r <= RST_INPUT_FILTER_RESISTANCE;
            nv_slope_r <= RST_EXT_TEMP_SLOPE;
            nv_offs_r <= RST_EXT_TEMP_OFFSET;
        end else if (store_all_in) begin
            nv_cfg_r <= cfg_r;
            nv_mode_r <= mode_r;
            nv_rail_r <= rail_r;
            nv_tc_r <= tc_r;
            nv_rvin_r <= rvin_r;
            nv_slope_r <= slope_r;
            nv_offs_r <= offs_r;
        end
    end
    // -----------------------------------------------------------------
    // fault log
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_any) log_wp_r <= '0;
        else if (fault_event_in) log_wp_r <= log_wp_r + 1'b1;
    end
    always_ff @(posedge clk_in) begin
        if (fault_event_in) ram_log[log_wp_r] <= fault_byte_in;
    end
    always_ff @(posedge clk_in) begin
        if (take && link.cmd == CMD_FAULT_LOG_COMMIT && link.kind == TX_SEND_BYTE
            && !log_lock_r) begin
            for (int i = 0; i < DEPTH; i++) nv_log[i] <= ram_log[i];
        end else if (take && link.cmd == CMD_FAULT_LOG_WIPE && link.kind == TX_SEND_BYTE) begin
            for (int i = 0; i < DEPTH; i++) nv_log[i] <= 8'h00;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) log_lock_r <= 1'b0;
        else if (take && link.kind == TX_SEND_BYTE && link.cmd == CMD_FAULT_LOG_WIPE)
            log_lock_r <= 1'b0;
        else if (take && link.kind == TX_SEND_BYTE && link.cmd == CMD_FAULT_LOG_COMMIT)
            log_lock_r <= 1'b1;
    end
    always_ff @(posedge clk_in) begin
        if (rst_any) off_r <= 1'b0;
        else if (take && link.kind == TX_SEND_BYTE && link.cmd == CMD_FAULT_LOG_COMMIT)
            off_r <= 1'b1;
    end
    // block readout advances one byte per read
    always_ff @(posedge clk_in) begin
        if (rst_any) rd_ptr_r <= '0;
        else if (take && link.cmd == CMD_FAULT_LOG_READOUT && link.kind == TX_READ_BLOCK)
            rd_ptr_r <= rd_ptr_r + 1'b1;
    end
    always_ff @(posedge clk_in) begin
        if (rst_any) mismatch_r <= 1'b0;
        else if (take && link.kind == TX_SEND_BYTE && link.cmd == CMD_NVM_COMPARE)
            mismatch_r <= {cfg_r, mode_r, rail_r, tc_r, rvin_r, slope_r, offs_r} !=
                {nv_cfg_r, nv_mode_r, nv_rail_r, nv_tc_r, nv_rvin_r, nv_slope_r, nv_offs_r};
    end
    // -----------------------------------------------------------------
    // answers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_any) comm_fault_r <= 1'b0;
        else if (take && wr_kind && listed == 3'd7) comm_fault_r <= 1'b1;
        else if (take && listed != 3'd7 && !kind_ok(listed, link.kind))
            comm_fault_r <= 1'b1;
    end
    always_ff @(posedge clk_in) begin
        if (rst_any) rdata_r <= 16'h0000;
        else if (take) begin
            if (link.cmd == CMD_CHANNEL_INPUT_CURRENT) rdata_r <= iin_r;
            else if (link.cmd == CMD_FAULT_LOG_READOUT) rdata_r <= {8'h00, nv_log[rd_ptr_r]};
            else if (link.cmd == CMD_COMMON_VENDOR_STATUS)
                rdata_r <= {8'h00, 1'b0, comm_fault_r, off_r, mismatch_r, 4'h0};
            else if (link.cmd == CMD_DIE_TEMPERATURE_PEAK) rdata_r <= peak_r;
            else if (link.cmd == CMD_PWM_PHASE_CONFIGURATION) rdata_r <= {8'h00, cfg_r};
            else if (link.cmd == CMD_PWM_MODE_BYTE) rdata_r <= {8'h00, mode_r};
            else if (link.cmd == CMD_SENSE_TEMP_COEFFICIENT) rdata_r <= tc_r;
            else if (link.cmd == CMD_INPUT_FILTER_RESISTANCE) rdata_r <= rvin_r;
            else if (link.cmd == CMD_EXT_TEMP_SLOPE) rdata_r <= slope_r;
            else if (link.cmd == CMD_EXT_TEMP_OFFSET) rdata_r <= offs_r;
            else if (link.cmd == CMD_RAIL_GROUP_ADDRESS) rdata_r <= {8'h00, rail_r};
            else rdata_r <= 16'h0000;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_any) begin
            ack_r <= 1'b0;
            req_seen_r <= 1'b0;
        end else if (take) begin
            ack_r <= 1'b1;
            req_seen_r <= 1'b1;
        end else if (!req_sync_r[1]) begin
            ack_r <= 1'b0;
            req_seen_r <= 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) soft_rst_r <= 1'b0;
        else soft_rst_r <= take && link.kind == TX_SEND_BYTE && link.cmd == CMD_SOFT_RESTART;
    end
    assign link.ack = ack_r;
    assign link.rdata = rdata_r;
    assign link.blk_len = 8'(DEPTH);
    assign link.comm_fault = comm_fault_r;
    assign pwm_mode_out = mode_r;
    assign ilim_high_range_out = mode_r[ILIM_RANGE_BIT];
    assign comp_select_out = cfg_r[COMP_HI_BIT:COMP_LO_BIT];
    assign rail_group_address_out = rail_r;
    assign channel_off_out = off_r;
    assign nvm_mismatch_out = mismatch_r;
endmodule

// file: logic/pmbus_tail_pkg.sv
// shared constants and types for the command-map tail device and its host
package pmbus_tail_pkg;
    // -----------------------------------------------------------------
    // command codes
    // -----------------------------------------------------------------
    localparam logic [7:0] CMD_PEAK_CLEAR = 8'hE3;
    localparam logic [7:0] CMD_FAULT_LOG_COMMIT = 8'hEA;
    localparam logic [7:0] CMD_FAULT_LOG_WIPE = 8'hEC;
    localparam logic [7:0] CMD_CHANNEL_INPUT_CURRENT = 8'hED;
    localparam logic [7:0] CMD_FAULT_LOG_READOUT = 8'hEE;
    localparam logic [7:0] CMD_COMMON_VENDOR_STATUS = 8'hEF;
    localparam logic [7:0] CMD_NVM_COMPARE = 8'hF0;
    localparam logic [7:0] CMD_DIE_TEMPERATURE_PEAK = 8'hF4;
    localparam logic [7:0] CMD_PWM_PHASE_CONFIGURATION = 8'hF5;
    localparam logic [7:0] CMD_SENSE_TEMP_COEFFICIENT = 8'hF6;
    localparam logic [7:0] CMD_INPUT_FILTER_RESISTANCE = 8'hF7;
    localparam logic [7:0] CMD_EXT_TEMP_SLOPE = 8'hF8;
    localparam logic [7:0] CMD_EXT_TEMP_OFFSET = 8'hF9;
    localparam logic [7:0] CMD_RAIL_GROUP_ADDRESS = 8'hFA;
    localparam logic [7:0] CMD_SOFT_RESTART = 8'hFD;
    localparam logic [7:0] CMD_PWM_MODE_BYTE = 8'hD4;
    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] RST_PWM_PHASE_CONFIGURATION = 8'h10;
    localparam logic [7:0] RST_PWM_MODE_BYTE = 8'hD2;
    localparam logic [15:0] RST_SENSE_TEMP_COEFFICIENT = 16'h0F3C;
    localparam logic [15:0] RST_INPUT_FILTER_RESISTANCE = 16'h12EE;
    localparam logic [15:0] RST_EXT_TEMP_SLOPE = 16'h4000;
    localparam logic [15:0] RST_EXT_TEMP_OFFSET = 16'h8000;
    localparam logic [7:0] RST_RAIL_GROUP_ADDRESS = 8'h80;
    localparam logic [15:0] RST_PEAK_TEMP = 16'h8000;
    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int COMM_FAULT_BIT = 6;
    localparam int ILIM_RANGE_BIT = 7;
    localparam int COMP_LO_BIT = 5;
    localparam int COMP_HI_BIT = 6;
    localparam int LIN_EXP_MSB = 15;
    localparam int LIN_EXP_LSB = 11;
    localparam int LIN_MANT_MSB = 10;
    localparam int LIN_FIXED_EXP = -12;
    localparam int LOG_DEPTH = 16;
    // -----------------------------------------------------------------
    // host register map (designer chosen)
    // -----------------------------------------------------------------
    localparam logic [3:0] HREG_CTRL = 4'h0;
    localparam logic [3:0] HREG_WDATA = 4'h1;
    localparam logic [3:0] HREG_STATUS = 4'h2;
    localparam logic [3:0] HREG_RDATA = 4'h3;
    localparam logic [3:0] HREG_LOG_LO = 4'h4;
    localparam logic [3:0] HREG_LOG_HI = 4'h5;
    localparam logic [7:0] LINK_DIV = 8'd4;
    localparam int LOG_BITS = 32;

    // transaction kinds on the link
    typedef enum logic [2:0] {
        TX_SEND_BYTE = 3'd0,
        TX_WRITE_BYTE = 3'd1,
        TX_WRITE_WORD = 3'd2,
        TX_READ_BYTE = 3'd3,
        TX_READ_WORD = 3'd4,
        TX_READ_BLOCK = 3'd5
    } tx_kind_t;

    // listed transaction kind of a command; 3'd7 means unpublished
    function automatic logic [2:0] listed_kind(input logic [7:0] cmd);
        logic [2:0] k;
        k = 3'd7;
        if (cmd == CMD_PEAK_CLEAR || cmd == CMD_FAULT_LOG_COMMIT) k = TX_SEND_BYTE;
        else if (cmd == CMD_FAULT_LOG_WIPE || cmd == CMD_NVM_COMPARE) k = TX_SEND_BYTE;
        else if (cmd == CMD_SOFT_RESTART) k = TX_SEND_BYTE;
        else if (cmd == CMD_CHANNEL_INPUT_CURRENT) k = TX_READ_WORD;
        else if (cmd == CMD_DIE_TEMPERATURE_PEAK) k = TX_READ_WORD;
        else if (cmd == CMD_FAULT_LOG_READOUT) k = TX_READ_BLOCK;
        else if (cmd == CMD_COMMON_VENDOR_STATUS) k = TX_READ_BYTE;
        else if (cmd == CMD_PWM_PHASE_CONFIGURATION) k = TX_WRITE_BYTE;
        else if (cmd == CMD_PWM_MODE_BYTE) k = TX_WRITE_BYTE;
        else if (cmd == CMD_RAIL_GROUP_ADDRESS) k = TX_WRITE_BYTE;
        else if (cmd >= CMD_SENSE_TEMP_COEFFICIENT && cmd <= CMD_EXT_TEMP_OFFSET) k = TX_WRITE_WORD;
        return k;
    endfunction

    // readable kind matches the writable one
    function automatic logic kind_ok(input logic [2:0] listed, input logic [2:0] got);
        logic ok;
        ok = (listed == got);
        if (listed == TX_WRITE_BYTE && got == TX_READ_BYTE) ok = 1'b1;
        if (listed == TX_WRITE_WORD && got == TX_READ_WORD) ok = 1'b1;
        return ok;
    endfunction
endpackage

// file: logic/pmbus_link_if.sv
// link between host controller and command-map device
`timescale 1ns/100ps
interface pmbus_link_if;
    logic link_clk;
    logic req;
    logic [2:0] kind;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    logic [7:0] blk_len;
    logic comm_fault;
    modport host (output link_clk, req, kind, cmd, wdata,
                  input ack, rdata, blk_len, comm_fault);
    modport device (input link_clk, req, kind, cmd, wdata,
                    output ack, rdata, blk_len, comm_fault);
endinterface

// file: logic/pmbus_tail_host.sv
// host controller: runs link transactions ordered through its register port
`timescale 1ns/100ps
module pmbus_tail_host
    import pmbus_tail_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    pmbus_link_if.host link,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out
);
    import pmbus_tail_pkg::*;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_DROP = 2'b11
    } state_t;
    // -----------------------------------------------------------------
    // link clock divider and synchronisers
    // -----------------------------------------------------------------
    logic [7:0] div_r;
    logic lclk_r;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_r <= 8'h00;
            lclk_r <= 1'b0;
        end else if (div_r == LINK_DIV - 8'd1) begin
            div_r <= 8'h00;
            lclk_r <= !lclk_r;
        end else div_r <= div_r + 8'd1;
    end
    logic [1:0] ack_sync_r;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) ack_sync_r <= 2'b00;
        else ack_sync_r <= {ack_sync_r[0], link.ack};
    end
    // -----------------------------------------------------------------
    // orders and transaction state
    // -----------------------------------------------------------------
    state_t state_r;
    logic [7:0] cmd_r;
    logic [2:0] kind_r;
    logic [15:0] wd_r, rd_r;
    logic busy, go;
    logic [LOG_BITS-1:0] log_r;
    logic [7:0] bytes_left_r;
    assign busy = state_r != ST_IDLE;
    // unpublished writes refused locally
    assign go = wr_in && addr_in == HREG_CTRL && !busy
        && !((wdata_in[10:8] == TX_WRITE_BYTE || wdata_in[10:8] == TX_WRITE_WORD)
             && listed_kind(wdata_in[7:0]) == 3'd7);
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) state_r <= ST_IDLE;
        else case (state_r)
            ST_IDLE: if (go) state_r <= ST_REQ;
            ST_REQ: if (ack_sync_r[1]) state_r <= ST_DROP;
            ST_DROP: if (!ack_sync_r[1]) state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cmd_r <= 8'h00;
            kind_r <= TX_SEND_BYTE;
        end else if (go) begin
            cmd_r <= wdata_in[7:0];
            kind_r <= wdata_in[10:8];
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) wd_r <= 16'h0000;
        else if (wr_in && addr_in == HREG_WDATA) wd_r <= wdata_in[15:0];
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) rd_r <= 16'h0000;
        else if (state_r == ST_REQ && ack_sync_r[1]) rd_r <= link.rdata;
    end
    // block bytes assemble into one log, newest at the bottom
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            log_r <= '0;
            bytes_left_r <= 8'h00;
        end else if (go && wdata_in[10:8] == TX_READ_BLOCK && bytes_left_r == 8'h00) begin
            log_r <= '0;
            bytes_left_r <= link.blk_len;
        end else if (state_r == ST_REQ && ack_sync_r[1] && kind_r == TX_READ_BLOCK) begin
            log_r <= {log_r[LOG_BITS-9:0], link.rdata[7:0]};
            bytes_left_r <= bytes_left_r - 8'h01;
        end
    end
    // -----------------------------------------------------------------
    // register read port
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) rdata_out <= 32'h0000_0000;
        else if (rd_in) begin
            if (addr_in == HREG_CTRL) rdata_out <= {21'h0, kind_r, cmd_r};
            else if (addr_in == HREG_WDATA) rdata_out <= {16'h0000, wd_r};
            else if (addr_in == HREG_STATUS)
                rdata_out <= {16'h0000, bytes_left_r, 6'h00, link.comm_fault, busy};
            else if (addr_in == HREG_RDATA) rdata_out <= {16'h0000, rd_r};
            else if (addr_in == HREG_LOG_LO) rdata_out <= log_r[31:0];
            else if (addr_in == HREG_LOG_HI) rdata_out <= 32'h0000_0000;
            else rdata_out <= 32'h0000_0000;
        end else rdata_out <= 32'h0000_0000;
    end
    assign link.link_clk = lclk_r;
    assign link.req = state_r == ST_REQ;
    assign link.kind = kind_r;
    assign link.cmd = cmd_r;
    assign link.wdata = wd_r;
endmodule

// file: tb/pmbus_link_assertions.sv
// link checker between host controller and command-map device
`timescale 1ns/100ps
module pmbus_link_assertions
    import pmbus_tail_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req,
    input wire logic [2:0] kind,
    input wire logic [7:0] cmd,
    input wire logic ack,
    input wire logic [7:0] blk_len,
    input wire logic comm_fault
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // write-kind transfer answered on a command that has no write kind
    sequence s_ro_write;
        ack && kind inside {TX_WRITE_BYTE, TX_WRITE_WORD} && cmd inside {[8'hEC:8'hF0], 8'hF4};
    endsequence
    sequence s_restart;
        ack && kind == TX_SEND_BYTE && cmd == CMD_SOFT_RESTART;
    endsequence
    property p_blk_len; ack |-> blk_len == 8'(LOG_DEPTH); endproperty
    property p_ack_cause; $rose(ack) |-> req; endproperty
    property p_ack_hold; ack && req && cmd != CMD_SOFT_RESTART |=> ack; endproperty
    property p_ack_drop; $fell(req) |-> ##[1:40] !ack; endproperty
    property p_req_hold;
        req && !ack && !$past(ack) && !$past(ack, 2) |=> req && $stable(cmd) && $stable(kind);
    endproperty
    property p_no_unpub;
        req && kind inside {TX_WRITE_BYTE, TX_WRITE_WORD}
            |-> cmd inside {8'hD4, 8'hE3, 8'hEA, [8'hEC:8'hF0], [8'hF4:8'hFA], 8'hFD};
    endproperty
    property p_ro_fault; s_ro_write |-> ##[0:3] comm_fault; endproperty
    property p_restart; s_restart |-> ##[1:20] !comm_fault; endproperty
    a_blk_len: assert property (p_blk_len) else $error("block length wrong");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without req");
    a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
    a_ack_drop: assert property (p_ack_drop) else $error("ack stuck");
    a_req_hold: assert property (p_req_hold) else $error("request changed");
    a_no_unpub: assert property (p_no_unpub) else $error("unpublished write");
    a_ro_fault: assert property (p_ro_fault) else $error("no fault flag");
    a_restart: assert property (p_restart) else $error("restart kept fault");
endmodule

// file: tb/tb_top.sv
// bench driving host registers and watching the device
`timescale 1ns/100ps
module tb_top;
    import pmbus_tail_pkg::*;
    logic clk_in = 0, rst_n_in = 0, wr = 0, rd = 0, fev = 0, sto = 0, rsto = 0, ilim, off, mis;
    logic [3:0] addr = 0;
    logic [31:0] wd = 0, rdv, rdo;
    logic [15:0] temp = 16'h0010;
    logic [7:0] fb = 0, mode, rail;
    logic [1:0] comp;
    logic [43:0] rows [13] = '{44'h4F600000F3C, 44'h4F7000012EE, 44'h4F800004000,
        44'h4F900008000, 44'h3FA00000080, 44'h3F500000010, 44'h3D4000000D2,
        44'h1FA005A0000, 44'h3FA0000005A, 44'h2F912340000, 44'h4F900001234,
        44'h40100000000, 44'h4ED00000020};
    int err_count = 0, comparisons = 0;
    pmbus_link_if lnk();
    pmbus_tail_host i_pmbus_tail_host(.clk_in, .rst_n_in, .link(lnk), .addr_in(addr),
        .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdo));
    pmbus_tail_device i_pmbus_tail_device(.clk_in, .rst_n_in, .link(lnk), .iout_in(16'h0040),
        .duty_in(8'h80), .die_temp_in(temp), .fault_event_in(fev), .fault_byte_in(fb),
        .store_all_in(sto), .restore_all_in(rsto), .pwm_mode_out(mode), .ilim_high_range_out(ilim),
        .comp_select_out(comp), .rail_group_address_out(rail), .channel_off_out(off),
        .nvm_mismatch_out(mis));
    pmbus_link_assertions i_pmbus_link_assertions(.clk_in, .rst_n_in, .req(lnk.req),
        .kind(lnk.kind), .cmd(lnk.cmd), .ack(lnk.ack), .blk_len(lnk.blk_len),
        .comm_fault(lnk.comm_fault));
    initial forever #10 clk_in = ~clk_in;
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr_r(logic [3:0] a, logic [31:0] d);
        @(posedge clk_in);
        addr <= a; wd <= d; wr <= 1;
        @(posedge clk_in);
        wr <= 0;
    endtask
    task automatic rd_r(logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr <= a; rd <= 1;
        @(posedge clk_in);
        rd <= 0;
        #1 d = rdo;
    endtask
    // one link transfer, then fetch its read result
    task automatic xact(logic [2:0] k, logic [7:0] c, logic [15:0] d, output logic [31:0] r);
        int i;
        wr_r(HREG_WDATA, {16'h0, d});
        wr_r(HREG_CTRL, {21'h0, k, c});
        repeat (2) @(posedge clk_in);
        r = 1;
        for (i = 0; i < 200 && r[0] !== 1'b0; i++) rd_r(HREG_STATUS, r);
        if (r[0] !== 1'b0) begin
            err_count++;
            close_out();
        end
        rd_r(HREG_RDATA, r);
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1;
        foreach (rows[j]) begin
            xact(rows[j][42:40], rows[j][39:32], rows[j][31:16], rdv);
            if (rows[j][42:40] > 3'd2) chk("row read", {16'h0, rows[j][15:0]}, rdv);
        end
        xact(TX_WRITE_BYTE, CMD_PWM_PHASE_CONFIGURATION, 16'h0060, rdv);
        chk("comp", 32'h3, 32'(comp));
        chk("ilim", 32'h1, 32'(ilim));
        xact(TX_WRITE_BYTE, CMD_PWM_MODE_BYTE, 16'h0052, rdv);
        chk("ilim low", 32'h0, 32'(ilim));
        chk("mode", 32'h52, 32'(mode));
        chk("rail", 32'h5A, 32'(rail));
        xact(TX_WRITE_WORD, CMD_CHANNEL_INPUT_CURRENT, 16'h1111, rdv);
        rd_r(HREG_STATUS, rdv);
        chk("fault", 32'h1, 32'(rdv[1]));
        xact(TX_READ_BYTE, CMD_COMMON_VENDOR_STATUS, 16'h0, rdv);
        chk("common", 32'h1, 32'(rdv[COMM_FAULT_BIT]));
        for (int j = 0; j < 4; j++) begin
            @(posedge clk_in);
            fb <= 8'hA1 + 8'(j); fev <= 1;
            @(posedge clk_in);
            fev <= 0;
        end
        xact(TX_SEND_BYTE, CMD_FAULT_LOG_COMMIT, 16'h0, rdv);
        chk("off", 32'h1, 32'(off));
        repeat (4) xact(TX_READ_BLOCK, CMD_FAULT_LOG_READOUT, 16'h0, rdv);
        rd_r(HREG_LOG_LO, rdv);
        chk("log", 32'hA1A2A3A4, rdv);
        chk("blk", 32'd16, 32'(lnk.blk_len));
        xact(TX_SEND_BYTE, CMD_FAULT_LOG_WIPE, 16'h0, rdv);
        xact(TX_READ_BLOCK, CMD_FAULT_LOG_READOUT, 16'h0, rdv);
        chk("wiped", 32'h0, rdv);
        @(posedge clk_in) temp <= 16'h0020;
        @(posedge clk_in) temp <= 16'h0015;
        xact(TX_READ_WORD, CMD_DIE_TEMPERATURE_PEAK, 16'h0, rdv);
        chk("peak", 32'h0020, rdv);
        xact(TX_SEND_BYTE, CMD_PEAK_CLEAR, 16'h0, rdv);
        xact(TX_READ_WORD, CMD_DIE_TEMPERATURE_PEAK, 16'h0, rdv);
        chk("peak clear", 32'h0015, rdv);
        @(posedge clk_in) sto <= 1;
        @(posedge clk_in) sto <= 0;
        xact(TX_SEND_BYTE, CMD_NVM_COMPARE, 16'h0, rdv);
        chk("same", 32'h0, 32'(mis));
        xact(TX_WRITE_WORD, CMD_SENSE_TEMP_COEFFICIENT, 16'h0100, rdv);
        xact(TX_SEND_BYTE, CMD_NVM_COMPARE, 16'h0, rdv);
        chk("differ", 32'h1, 32'(mis));
        @(posedge clk_in) rsto <= 1;
        @(posedge clk_in) rsto <= 0;
        xact(TX_READ_WORD, CMD_SENSE_TEMP_COEFFICIENT, 16'h0, rdv);
        chk("restore", 32'h0F3C, rdv);
        xact(TX_SEND_BYTE, CMD_NVM_COMPARE, 16'h0, rdv);
        chk("same again", 32'h0, 32'(mis));
        xact(TX_SEND_BYTE, CMD_SOFT_RESTART, 16'h0, rdv);
        repeat (4) @(posedge clk_in);
        chk("restart rail", 32'h80, 32'(rail));
        close_out();
    end
endmodule
